// file: hdl/cmc_pkg.sv
// shared constants and carrier types of the camera mode configuration block
`default_nettype none

package cmc_pkg;

   // ------------------------------------------------------------
   // clock and timing
   // ------------------------------------------------------------
   localparam int unsigned CLK_HZ = 25000000;
   localparam int unsigned FPS_NORMAL = 30;
   localparam int unsigned FPS_PARTIAL = 60;
   localparam int unsigned FRAME_NORMAL_CYCLES = CLK_HZ / FPS_NORMAL;
   localparam int unsigned FRAME_PARTIAL_CYCLES = CLK_HZ / FPS_PARTIAL;
   // internal cyclic trigger, pulse width in ns
   localparam int unsigned TRIG_PULSE_NS = 1000;
   localparam int unsigned TRIG_PULSE_CYCLES = (TRIG_PULSE_NS * (CLK_HZ / 1000000) + 999) / 1000;
   localparam int unsigned FRAME_CNT_W = 20;

   // ------------------------------------------------------------
   // readout geometry
   // ------------------------------------------------------------
   localparam int unsigned LINE_W = 11;
   localparam logic [10:0] PARTIAL_LINES = 11'h18e;
   localparam logic [10:0] SENSOR_LINES_DEFAULT = 11'h410;

   // ------------------------------------------------------------
   // mode configuration register layout
   // ------------------------------------------------------------
   localparam int unsigned CFG_W = 16;
   localparam int unsigned BIT_ASYNC = 0;
   localparam int unsigned BIT_PWC = 1;
   localparam int unsigned BIT_LONG_EXP = 2;
   localparam int unsigned BIT_PARTIAL = 3;
   localparam int unsigned ESP_LSB = 8;
   localparam int unsigned ESP_W = 4;
   localparam int unsigned BIT_ESP_VALID = 12;
   localparam logic [15:0] CFG_RESET = 16'h0000;
   localparam logic [15:0] CFG_USED_MASK = 16'h1f0f;
   localparam logic [15:0] CFG_ALL_MASK = 16'hffff;

   // ------------------------------------------------------------
   // shutter position codes
   // ------------------------------------------------------------
   localparam logic [3:0] POS_RESET = 4'h0;
   localparam logic [3:0] POS_MAX_DIGIT = 4'h9;
   localparam logic [3:0] POS_H_UNIT = 4'hf;
   localparam logic [3:0] POS_PULSE_WIDTH = 4'h9;

   // ------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic en;
      logic [15:0] mask;
      logic [15:0] data;
   } cmc_wr_t;

   typedef struct packed {
      logic async_shutter_select;
      logic pulse_width_ctrl_enable;
      logic long_exposure_select;
      logic partial_scan_select;
      logic ext_shutter_position_valid;
      logic [3:0] ext_shutter_position;
   } cmc_mode_t;

   typedef struct packed {
      logic [15:0] cfg;
      logic [3:0] pos;
      logic h_unit;
      logic pw_exp;
      logic [10:0] lines;
      logic [10:0] first;
      cmc_mode_t mode;
   } cmc_top_state_t;

   typedef struct packed {
      logic [19:0] cnt;
      logic start;
   } cmc_frame_state_t;

   typedef struct packed {
      logic [19:0] cnt;
      logic trig;
   } cmc_trig_state_t;

endpackage

`default_nettype wire

// file: hdl/cmc_frame_timer.sv
// frame start pulse generator for normal or partial scan rate
`timescale 1ns/1ps
`default_nettype none

module cmc_frame_timer #(
   parameter int unsigned NORMAL_CYCLES = cmc_pkg::FRAME_NORMAL_CYCLES,
   parameter int unsigned PARTIAL_CYCLES = cmc_pkg::FRAME_PARTIAL_CYCLES
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic partial_in,
   output logic frame_start_out
);

   localparam logic [19:0] LAST_NORMAL = 20'(NORMAL_CYCLES - 1);
   localparam logic [19:0] LAST_PARTIAL = 20'(PARTIAL_CYCLES - 1);

   cmc_pkg::cmc_frame_state_t st_reg;
   cmc_pkg::cmc_frame_state_t st_next;
   logic [19:0] last;

   always_comb begin
      st_next = st_reg;
      last = partial_in ? LAST_PARTIAL : LAST_NORMAL;
      st_next.start = 1'b0;
      if (st_reg.cnt >= last) begin
         st_next.cnt = 20'h00000;
         st_next.start = 1'b1;
      end else begin
         st_next.cnt = st_reg.cnt + 20'h00001;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign frame_start_out = st_reg.start;

endmodule // cmc_frame_timer

`default_nettype wire

// file: hdl/cmc_cyclic_trigger.sv
// internal periodic shutter trigger used while the menu is shown in async shutter
`timescale 1ns/1ps
`default_nettype none

module cmc_cyclic_trigger #(
   parameter int unsigned PERIOD_CYCLES = cmc_pkg::FRAME_NORMAL_CYCLES,
   parameter int unsigned HIGH_CYCLES = cmc_pkg::TRIG_PULSE_CYCLES
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic run_in,
   output logic trig_out
);

   localparam logic [19:0] LAST = 20'(PERIOD_CYCLES - 1);
   localparam logic [19:0] HIGH = 20'(HIGH_CYCLES);

   cmc_pkg::cmc_trig_state_t st_reg;
   cmc_pkg::cmc_trig_state_t st_next;

   always_comb begin
      st_next = st_reg;
      if (!run_in) begin
         st_next.cnt = 20'h00000;
         st_next.trig = 1'b0;
      end else begin
         // pulse opens each period, stays high for HIGH cycles;
         // decoded from the current count so the first pulse after run is full width
         st_next.cnt = (st_reg.cnt >= LAST) ? 20'h00000 : st_reg.cnt + 20'h00001;
         st_next.trig = (st_reg.cnt < HIGH);
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign trig_out = st_reg.trig;

endmodule // cmc_cyclic_trigger

`default_nettype wire

// file: hdl/cmc_mode_config.sv
// camera operating mode configuration register and mode selection
//
// Notes on behaviour
// - bit 0 set selects asynchronous shutter
// - bit 1 set enables pulse width exposure
// - bit 2 set selects long exposure shutter
// - bit 3 set selects partial scan readout
// - bits 8..11 hold position 0-9 or F
// - bit 12 set applies the external position
// - all bits zero after factory reset
// - panel switch changes update the register
// - normal scan reads whole frame, 30 fps
// - partial scan reads central 398 lines, 60 fps
// - written combinations are taken unchecked
// - position 9 differs between shutter modes
// - pulse width may stay off at position 9
// - menu shown in async shutter makes internal cyclic trigger
// - power-on copies stored word into register
// - one stored copy, independent of pages
`timescale 1ns/1ps
`default_nettype none

module cmc_mode_config #(
   parameter int unsigned FRAME_NORMAL_CYCLES = cmc_pkg::FRAME_NORMAL_CYCLES,
   parameter int unsigned FRAME_PARTIAL_CYCLES = cmc_pkg::FRAME_PARTIAL_CYCLES,
   parameter int unsigned TRIG_PERIOD_CYCLES = cmc_pkg::FRAME_NORMAL_CYCLES,
   parameter int unsigned TRIG_HIGH_CYCLES = cmc_pkg::TRIG_PULSE_CYCLES,
   parameter logic [10:0] SENSOR_LINES = cmc_pkg::SENSOR_LINES_DEFAULT
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   // stored copy presented at power-on
   input wire cmc_pkg::cmc_wr_t nv_load_in,
   // serial register write command
   input wire cmc_pkg::cmc_wr_t cmd_write_in,
   // rear-panel switch change
   input wire cmc_pkg::cmc_wr_t panel_write_in,
   input wire logic [3:0] mode_switch_in,
   input wire logic menu_shown_in,
   output logic [15:0] operating_mode_config_out,
   output cmc_pkg::cmc_mode_t mode_out,
   output logic [3:0] shutter_position_out,
   output logic h_unit_select_out,
   output logic pulse_width_exposure_out,
   output logic [10:0] readout_lines_out,
   output logic [10:0] readout_first_line_out,
   output logic frame_start_out,
   output logic cyclic_trigger_out
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   cmc_pkg::cmc_top_state_t st_reg;
   cmc_pkg::cmc_top_state_t st_next;
   logic [15:0] merged;
   logic [3:0] req_pos;
   logic pos_ok;
   logic trig_run;

   // ------------------------------------------------------------
   // register update
   // ------------------------------------------------------------
   always_comb begin
      st_next = st_reg;
      merged = st_reg.cfg;
      // stored copy first, serial command over panel within one cycle
      if (nv_load_in.en) begin
         merged = nv_load_in.data;
      end else if (cmd_write_in.en) begin
         // no compatibility check on written values
         merged = (merged & ~cmd_write_in.mask) | (cmd_write_in.data & cmd_write_in.mask);
      end else if (panel_write_in.en) begin
         merged = (merged & ~panel_write_in.mask)
                | (panel_write_in.data & panel_write_in.mask);
      end
      st_next.cfg = merged & cmc_pkg::CFG_USED_MASK;

      // decoded mode fields from the stored register
      st_next.mode.async_shutter_select = st_reg.cfg[cmc_pkg::BIT_ASYNC];
      st_next.mode.pulse_width_ctrl_enable = st_reg.cfg[cmc_pkg::BIT_PWC];
      st_next.mode.long_exposure_select = st_reg.cfg[cmc_pkg::BIT_LONG_EXP];
      st_next.mode.partial_scan_select = st_reg.cfg[cmc_pkg::BIT_PARTIAL];
      st_next.mode.ext_shutter_position_valid = st_reg.cfg[cmc_pkg::BIT_ESP_VALID];
      st_next.mode.ext_shutter_position = st_reg.cfg[cmc_pkg::ESP_LSB +: cmc_pkg::ESP_W];

      // ------------------------------------------------------------
      // shutter position selection
      // ------------------------------------------------------------
      if (st_reg.cfg[cmc_pkg::BIT_ESP_VALID]) begin
         req_pos = st_reg.cfg[cmc_pkg::ESP_LSB +: cmc_pkg::ESP_W];
      end else begin
         req_pos = mode_switch_in;
      end
      pos_ok = (req_pos <= cmc_pkg::POS_MAX_DIGIT) || (req_pos == cmc_pkg::POS_H_UNIT);
      if (pos_ok) begin
         st_next.pos = req_pos;
      end else begin
         st_next.pos = st_reg.pos;
      end
      st_next.h_unit = (st_next.pos == cmc_pkg::POS_H_UNIT);

      // position 9 exposure follows the trigger width only in async with pwc on;
      // otherwise position 9 uses the table of the active shutter mode
      st_next.pw_exp = st_reg.cfg[cmc_pkg::BIT_ASYNC] && st_reg.cfg[cmc_pkg::BIT_PWC]
                     && (st_next.pos == cmc_pkg::POS_PULSE_WIDTH);

      // ------------------------------------------------------------
      // readout band
      // ------------------------------------------------------------
      if (st_reg.cfg[cmc_pkg::BIT_PARTIAL]) begin
         st_next.lines = cmc_pkg::PARTIAL_LINES;
         st_next.first = 11'((SENSOR_LINES - cmc_pkg::PARTIAL_LINES) >> 1);
      end else begin
         st_next.lines = SENSOR_LINES;
         st_next.first = 11'h000;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_reg.cfg <= cmc_pkg::CFG_RESET;
         st_reg.pos <= cmc_pkg::POS_RESET;
         st_reg.h_unit <= 1'b0;
         st_reg.pw_exp <= 1'b0;
         st_reg.lines <= SENSOR_LINES;
         st_reg.first <= 11'h000;
         st_reg.mode <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // ------------------------------------------------------------
   // frame rate and internal trigger
   // ------------------------------------------------------------
   // trigger only while the menu is up in async shutter, so setup needs no user pulses
   assign trig_run = menu_shown_in && st_reg.cfg[cmc_pkg::BIT_ASYNC];

   cmc_frame_timer #(
      .NORMAL_CYCLES(FRAME_NORMAL_CYCLES),
      .PARTIAL_CYCLES(FRAME_PARTIAL_CYCLES)
   ) u_frame (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .partial_in(st_reg.cfg[cmc_pkg::BIT_PARTIAL]),
      .frame_start_out(frame_start_out)
   );

   cmc_cyclic_trigger #(
      .PERIOD_CYCLES(TRIG_PERIOD_CYCLES),
      .HIGH_CYCLES(TRIG_HIGH_CYCLES)
   ) u_trig (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .run_in(trig_run),
      .trig_out(cyclic_trigger_out)
   );

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign operating_mode_config_out = st_reg.cfg;
   assign mode_out = st_reg.mode;
   assign shutter_position_out = st_reg.pos;
   assign h_unit_select_out = st_reg.h_unit;
   assign pulse_width_exposure_out = st_reg.pw_exp;
   assign readout_lines_out = st_reg.lines;
   assign readout_first_line_out = st_reg.first;

endmodule // cmc_mode_config

`default_nettype wire

// file: tb/cmc_mode_config_monitor.sv
// port checker for the mode configuration block
`timescale 1ns/1ps
`default_nettype none

module cmc_mode_config_monitor #(
   parameter logic [10:0] SENSOR_LINES = cmc_pkg::SENSOR_LINES_DEFAULT
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire cmc_pkg::cmc_wr_t nv_load_in,
   input wire cmc_pkg::cmc_wr_t cmd_write_in,
   input wire logic menu_shown_in,
   input wire logic [15:0] operating_mode_config_out,
   input wire cmc_pkg::cmc_mode_t mode_out,
   input wire logic [3:0] shutter_position_out,
   input wire logic h_unit_select_out,
   input wire logic [10:0] readout_lines_out,
   input wire logic [10:0] readout_first_line_out,
   input wire logic cyclic_trigger_out
);
   logic [15:0] cfg;
   logic [8:0] fields;
   assign cfg = operating_mode_config_out;
   assign fields = {cfg[0], cfg[1], cfg[2], cfg[3], cfg[12], cfg[11:8]};
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   // ------------------------------------------------------------
   // sequences and assertions
   // ------------------------------------------------------------
   sequence s_cmd_only;
      cmd_write_in.en && !nv_load_in.en;
   endsequence
   sequence s_bad_code;
      cfg[12] && cfg[11:8] inside {[4'ha:4'he]};
   endsequence
   a_unused_bits_zero:
      assert property ((cfg & 16'he0f0) == 16'h0000) else $error("unused bit set");
   a_stored_word_load:
      assert property (nv_load_in.en |=> cfg == ($past(nv_load_in.data) & 16'h1f0f))
      else $error("stored word not taken");
   a_cmd_write_taken:
      assert property (s_cmd_only |=> cfg == ((($past(cfg) & ~$past(cmd_write_in.mask))
         | ($past(cmd_write_in.data) & $past(cmd_write_in.mask))) & 16'h1f0f))
      else $error("serial write not taken");
   a_mode_fields_follow:
      assert property (mode_out == $past(fields)) else $error("mode fields wrong");
   a_hunit_code_applied:
      assert property (cfg[12] && cfg[11:8] == 4'hf |=> shutter_position_out == 4'hf
         && h_unit_select_out) else $error("code f not applied");
   a_bad_code_holds:
      assert property (s_bad_code |=> $stable(shutter_position_out))
      else $error("invalid code moved position");
   a_partial_band:
      assert property (cfg[3] |=> readout_lines_out == 11'h18e
         && readout_first_line_out == ((SENSOR_LINES - 11'h18e) >> 1))
      else $error("partial band wrong");
   a_normal_frame:
      assert property (!cfg[3] |=> readout_lines_out == SENSOR_LINES
         && readout_first_line_out == 11'h000) else $error("normal frame wrong");
   a_trigger_menu_off:
      assert property (!menu_shown_in |=> !cyclic_trigger_out) else $error("stray trigger");
endmodule // cmc_mode_config_monitor

bind cmc_mode_config cmc_mode_config_monitor #(.SENSOR_LINES(SENSOR_LINES)) u_mon (
   .clk_in(clk_in), .rst_n_in(rst_n_in), .nv_load_in(nv_load_in),
   .cmd_write_in(cmd_write_in), .menu_shown_in(menu_shown_in),
   .operating_mode_config_out(operating_mode_config_out), .mode_out(mode_out),
   .shutter_position_out(shutter_position_out), .h_unit_select_out(h_unit_select_out),
   .readout_lines_out(readout_lines_out), .readout_first_line_out(readout_first_line_out),
   .cyclic_trigger_out(cyclic_trigger_out));

`default_nettype wire

// file: tb/cmc_host_model.sv
// host and rear panel model driving the configuration write ports
`timescale 1ns/1ps
`default_nettype none

module cmc_host_model (
   input wire logic clk_in,
   output var cmc_pkg::cmc_wr_t nv_load_out,
   output var cmc_pkg::cmc_wr_t cmd_write_out,
   output var cmc_pkg::cmc_wr_t panel_write_out
);
   initial begin
      nv_load_out = '0;
      cmd_write_out = '0;
      panel_write_out = '0;
   end
   // sel: bit 2 stored load, bit 1 serial, bit 0 panel; panel gets inverted data when bit 1 is also set
   // callers pick the word; the fields and sources tests both pair long exposure with partial
   // block has no trigger pin; in async shutter the internal cyclic trigger supplies the setup pulses while the menu is shown
   task automatic send(input logic [2:0] sel, input logic [15:0] mask, input logic [15:0] data);
      @(negedge clk_in);
      nv_load_out = '{sel[2], mask, data};
      cmd_write_out = '{sel[1], mask, data};
      panel_write_out = '{sel[0], mask, sel[1] ? ~data : data};
      @(negedge clk_in);
      // released ports show the inverse, except that panel keeps its mask and, after a serial send, its last data word
      nv_load_out = '{1'b0, ~mask, ~data};
      cmd_write_out = '{1'b0, ~mask, ~data};
      panel_write_out = '{1'b0, mask, ~data};
   endtask
endmodule // cmc_host_model

`default_nettype wire

// file: tb/cmc_mode_config_test.sv
// self-checking bench for the mode configuration block
`timescale 1ns/1ps
`default_nettype none

module cmc_mode_config_test;
   localparam logic [10:0] SENSOR_LINES = 11'h410;
   logic clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic [3:0] mode_switch_in = 4'h0;
   logic menu_shown_in = 1'b0;
   cmc_pkg::cmc_wr_t nv, cmd, panel;
   cmc_pkg::cmc_mode_t mode;
   logic [15:0] cfg;
   logic [3:0] pos;
   logic h_unit, pw_exp, frame, trig;
   logic [10:0] lines, first;
   int num_errors = 0;
   int check_count = 0;
   int g, hi, per;
   logic prev;

   always #20 clk_in = ~clk_in;

   cmc_host_model u_cmc_host_model (.clk_in(clk_in), .nv_load_out(nv),
      .cmd_write_out(cmd), .panel_write_out(panel));
   cmc_mode_config #(.FRAME_NORMAL_CYCLES(200), .FRAME_PARTIAL_CYCLES(100),
      .TRIG_PERIOD_CYCLES(100), .TRIG_HIGH_CYCLES(4), .SENSOR_LINES(SENSOR_LINES))
   u_cmc_mode_config (.clk_in(clk_in), .rst_n_in(rst_n_in), .nv_load_in(nv),
      .cmd_write_in(cmd), .panel_write_in(panel), .mode_switch_in(mode_switch_in),
      .menu_shown_in(menu_shown_in), .operating_mode_config_out(cfg), .mode_out(mode),
      .shutter_position_out(pos), .h_unit_select_out(h_unit),
      .pulse_width_exposure_out(pw_exp), .readout_lines_out(lines),
      .readout_first_line_out(first), .frame_start_out(frame), .cyclic_trigger_out(trig));

   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic put(input logic [2:0] sel, input logic [15:0] mask, input logic [15:0] w);
      u_cmc_host_model.send(sel, mask, w);
      @(negedge clk_in);
   endtask
   task automatic frame_gap();
      g = 0;
      while (frame !== 1'b1 && g < 500) begin
         @(negedge clk_in);
         g++;
      end
      g = 0;
      do begin
         @(negedge clk_in);
         g++;
      end while (frame !== 1'b1 && g < 500);
   endtask
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_fields();
      check(cfg, 16'h0000);
      check(16'(lines), 16'(SENSOR_LINES));
      for (int i = 0; i < 4; i++) begin
         put(3'b010, 16'hffff, 16'h0001 << i);
         check(16'({mode.partial_scan_select, mode.long_exposure_select,
            mode.pulse_width_ctrl_enable, mode.async_shutter_select}), 16'h0001 << i);
      end
      put(3'b010, 16'hffff, 16'hffff);
      check(cfg, 16'h1f0f);
      $display("fields test over");
   endtask
   task automatic t_position();
      mode_switch_in = 4'h3;
      put(3'b010, 16'hffff, 16'h1500);
      check(16'(pos), 16'h0005);
      put(3'b010, 16'hffff, 16'h1f00);
      check(16'({h_unit, pos}), 16'h001f);
      put(3'b010, 16'hffff, 16'h1b00);
      check(16'(pos), 16'h000f);
      put(3'b010, 16'hffff, 16'h0b00);
      check(16'(pos), 16'h0003);
      mode_switch_in = 4'h9;
      put(3'b010, 16'hffff, 16'h0003);
      check(16'(pw_exp), 16'h0001);
      put(3'b010, 16'hffff, 16'h0002);
      check(16'(pw_exp), 16'h0000);
      put(3'b010, 16'hffff, 16'h0001);
      check(16'(pw_exp), 16'h0000);
      $display("position test over");
   endtask
   task automatic t_sources();
      put(3'b010, 16'hffff, 16'h000c);
      check(cfg, 16'h000c);
      check(16'(lines), 16'h018e);
      check(16'(first), 16'h0141);
      put(3'b001, 16'h0001, 16'h0001);
      check(cfg, 16'h000d);
      put(3'b011, 16'hffff, 16'h0008);
      check(cfg, 16'h0008);
      put(3'b100, 16'h0000, 16'h1234);
      check(cfg, 16'h1204);
      $display("sources test over");
   endtask
   task automatic t_timing();
      put(3'b010, 16'hffff, 16'h0001);
      frame_gap();
      frame_gap();
      check(16'(g), 16'h00c8);
      menu_shown_in = 1'b1;
      per = 0;
      while (trig !== 1'b1 && per < 300) begin
         @(negedge clk_in);
         per++;
      end
      hi = 0;
      per = 0;
      do begin
         hi += int'(trig === 1'b1);
         prev = trig;
         @(negedge clk_in);
         per++;
      end while (!(trig === 1'b1 && prev !== 1'b1) && per < 300);
      check(16'(hi), 16'h0004);
      check(16'(per), 16'h0064);
      menu_shown_in = 1'b0;
      put(3'b010, 16'hffff, 16'h0008);
      frame_gap();
      frame_gap();
      check(16'(g), 16'h0064);
      check(16'(trig), 16'h0000);
      $display("timing test over");
   endtask

   initial begin
      #(40 * 20000);
      num_errors++;
      $display("wrong value at %0t: watchdog expired", $time);
      test_done();
   end

   initial begin
      repeat (20) @(negedge clk_in);
      rst_n_in = 1'b1;
      t_fields();
      t_position();
      t_sources();
      t_timing();
      test_done();
   end
endmodule // cmc_mode_config_test

`default_nettype wire
